//--- design/pfi_regs.svh
`ifndef PFI_REGS_SVH
`define PFI_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PFI_OFF_PE_VER   12'h000
`define PFI_OFF_PE_IDR   12'h004
`define PFI_OFF_PE_CTRL  12'h008
`define PFI_OFF_AIDR     12'h010
`define PFI_OFF_IDR_LO   12'h014
`define PFI_OFF_IDR_HI   12'h018
`define PFI_OFF_IMPL_IDR 12'h01C
`define PFI_OFF_BANDWIDTH_USAGE_COUNTER_IDR 12'h020

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PFI_PEIDR_TRAP   0
`define PFI_PEIDR_SDEF   1
`define PFI_PEIDR_FORCE  2
`define PFI_CTRL_SDEF    0
`define PFI_CTRL_FORCE   1
`define PFI_IDR_HAS_IMPL 0
`define PFI_IDR_INSTANCE_SELECT_PRESENT_FLAG  1
`define PFI_IDR_ERROR_STATUS_PRESENT_FLAG  2
`define PFI_IDR_HAS_EXTD 3
`define PFI_IDR_EXT      31
`define PFI_IDRH_NO_PART 0
`define PFI_IDRH_NO_MON  1
`define PFI_BANDWIDTH_USAGE_COUNTER_LONG    0

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define PFI_VER_ZERO     4'h0
`define PFI_VER_ONE      4'h1
`define PFI_LONG_W_SHORT 8'h2C
`define PFI_LONG_W_WIDE  8'h3F
`define PFI_CTRL_RST     2'h0

`endif

//--- design/pfi_pkg.sv
package pfi_pkg;

  // Version that the processing element advertises
  typedef enum logic [1:0] {
    PFI_PE_NONE,
    PFI_PE_V01,
    PFI_PE_V10,
    PFI_PE_V11
  } pfi_pe_ver_e;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pfi_apb_req_s;

  // Processing element identification fields
  typedef struct packed {
    logic [3:0] major;
    logic [3:0] frac;
    logic trap;
    logic secure_default_bit;
    logic force_nonsecure_bit;
  } pfi_pe_id_s;

  // Memory-system component identification fields
  typedef struct packed {
    logic [3:0] major;
    logic [3:0] minor;
    logic extended_id_flag;
    logic has_impl;
    logic no_part;
    logic no_mon;
    logic instance_select_present_flag;
    logic error_status_present_flag;
    logic has_extd;
    logic has_long;
    logic [7:0] cnt_w;
  } pfi_msc_id_s;

endpackage

//--- design/pfi_pe_id.sv
`timescale 1ns/1ps
`include "pfi_regs.svh"

module pfi_pe_id #(
  parameter pfi_pkg::pfi_pe_ver_e VER = pfi_pkg::PFI_PE_V11,
  parameter bit SECURE_DEFAULT_PRESENT_FLAG = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Identification fields
  output pfi_pkg::pfi_pe_id_s id
);
  import pfi_pkg::*;

  // ----------------------------------------------------------------
  // Legal encoding per version
  // ----------------------------------------------------------------
  function automatic pfi_pe_id_s mk_id(input pfi_pe_ver_e v);
    pfi_pe_id_s r;
    r = '0;
    case (v)
      PFI_PE_V01: begin
        r.frac = `PFI_VER_ONE;
        r.trap = 1'b1;
        r.secure_default_bit = SECURE_DEFAULT_PRESENT_FLAG;
        r.force_nonsecure_bit = 1'b1;
      end
      PFI_PE_V10: begin
        r.major = `PFI_VER_ONE;
        r.secure_default_bit = 1'b0;
      end
      PFI_PE_V11: begin
        r.major = `PFI_VER_ONE;
        r.frac = `PFI_VER_ONE;
        r.trap = 1'b1;
        r.secure_default_bit = SECURE_DEFAULT_PRESENT_FLAG;
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  localparam pfi_pe_id_s ID_C = mk_id(VER);

  // Held constant from reset onward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id <= ID_C;
    end else begin
      id <= ID_C;
    end
  end

endmodule

//--- design/pfi_msc_id.sv
`timescale 1ns/1ps
`include "pfi_regs.svh"

module pfi_msc_id #(
  parameter bit MSC_EN = 1'b1,
  parameter bit HAS_IMPL = 1'b1,
  parameter bit NO_PART = 1'b1,
  parameter bit NO_MON = 1'b0,
  parameter bit INSTANCE_SELECT_PRESENT_FLAG = 1'b1,
  parameter bit ERROR_STATUS_PRESENT_FLAG = 1'b1,
  parameter bit HAS_EXTD = 1'b0,
  parameter bit HAS_LONG = 1'b1,
  parameter int LONG_W = 44
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Identification fields
  output pfi_pkg::pfi_msc_id_s id
);
  import pfi_pkg::*;

  // ----------------------------------------------------------------
  // Version follows from the features actually built
  // ----------------------------------------------------------------
  function automatic pfi_msc_id_s mk_id();
    pfi_msc_id_s r;
    logic v11;
    r = '0;
    // No newer feature means the older version
    v11 = MSC_EN && (HAS_IMPL || INSTANCE_SELECT_PRESENT_FLAG || ERROR_STATUS_PRESENT_FLAG || HAS_EXTD || HAS_LONG);
    if (MSC_EN) begin
      r.major = `PFI_VER_ONE;
    end
    if (v11) begin
      r.minor = `PFI_VER_ONE;
      r.extended_id_flag = 1'b1;
      r.has_impl = HAS_IMPL;
      r.no_part = HAS_IMPL && NO_PART;
      r.no_mon = HAS_IMPL && NO_MON;
      r.instance_select_present_flag = INSTANCE_SELECT_PRESENT_FLAG;
      r.error_status_present_flag = ERROR_STATUS_PRESENT_FLAG;
      // Widened status is forced when both parents exist
      r.has_extd = ERROR_STATUS_PRESENT_FLAG && (HAS_EXTD || INSTANCE_SELECT_PRESENT_FLAG);
      r.has_long = HAS_LONG;
      // Only two counter widths are legal
      r.cnt_w = !HAS_LONG ? 8'h00 : (LONG_W == 63) ? `PFI_LONG_W_WIDE
                                                   : `PFI_LONG_W_SHORT;
    end
    return r;
  endfunction

  localparam pfi_msc_id_s ID_C = mk_id();

  // Held constant from reset onward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id <= ID_C;
    end else begin
      id <= ID_C;
    end
  end

endmodule

//--- design/pfi_top.sv
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "pfi_regs.svh"

// How it works
// - Both version fields zero: no extension
// - Version 0.1: force bit disables secure labels
// - Version 1.0: no newer features
// - Version 1.1: all features, no force bit
// - Component id never shows major 0 minor 1
// - Component 1.0 has 32-bit feature register
// - Component 1.1 has 64-bit feature register
// - No newer feature means component 1.0
// - Version 1.1 element reports trap present
// - Secure default emits label zero when secure
// - Element 1.0 reports no secure default
// - Only 0.1 implements and reports force bit
// - Component 1.1 sets extended flag
// - Description flags blank implementation register fields
// - Instance selection needs extended and its flag
// - Long counters are 44 or 63 bits
// - Component 1.1 reports error status presence
// - Widened status forced with status and selection

module pfi_top #(
  parameter pfi_pkg::pfi_pe_ver_e PE_VER = pfi_pkg::PFI_PE_V11,
  parameter bit PE_SECURE_DEFAULT_BIT = 1'b1,
  parameter bit FORCE_NONSECURE_BIT_RW = 1'b1,
  parameter bit MSC_EN = 1'b1,
  parameter bit HAS_IMPL = 1'b1,
  parameter bit NO_PART = 1'b1,
  parameter bit NO_MON = 1'b0,
  parameter bit INSTANCE_SELECT_PRESENT_FLAG = 1'b1,
  parameter bit ERROR_STATUS_PRESENT_FLAG = 1'b1,
  parameter bit HAS_EXTD = 1'b0,
  parameter bit HAS_LONG = 1'b1,
  parameter int LONG_W = 44,
  parameter int PARTITION_LABEL_W = 16,
  parameter int PMG_W = 8,
  parameter logic [7:0] IMPL_PART_N = 8'h03,
  parameter logic [7:0] IMPL_MON_N = 8'h02
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input pfi_pkg::pfi_apb_req_s apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Label request from the element core
  input wire logic req_valid,
  input wire logic req_secure,
  input wire logic [PARTITION_LABEL_W-1:0] req_partition_label,
  input wire logic [PMG_W-1:0] req_pmg,
  // Label sent to the memory system
  output logic out_valid,
  output logic out_ns,
  output logic [PARTITION_LABEL_W-1:0] out_partition_label,
  output logic [PMG_W-1:0] out_pmg
);
  import pfi_pkg::*;

  // ----------------------------------------------------------------
  // Identification sources
  // ----------------------------------------------------------------
  pfi_pe_id_s pe_id; // Element fields, constant after reset
  pfi_msc_id_s msc_id; // Component fields, constant after reset

  pfi_pe_id #(
    .VER(PE_VER),
    .SECURE_DEFAULT_PRESENT_FLAG(PE_SECURE_DEFAULT_BIT)
  ) u_pe_id (
    .pclk(pclk),
    .presetn(presetn),
    .id(pe_id)
  );

  pfi_msc_id #(
    .MSC_EN(MSC_EN),
    .HAS_IMPL(HAS_IMPL),
    .NO_PART(NO_PART),
    .NO_MON(NO_MON),
    .INSTANCE_SELECT_PRESENT_FLAG(INSTANCE_SELECT_PRESENT_FLAG),
    .ERROR_STATUS_PRESENT_FLAG(ERROR_STATUS_PRESENT_FLAG),
    .HAS_EXTD(HAS_EXTD),
    .HAS_LONG(HAS_LONG),
    .LONG_W(LONG_W)
  ) u_msc_id (
    .pclk(pclk),
    .presetn(presetn),
    .id(msc_id)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Word match on a register offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a[11:2] == off[11:2];
  endfunction

  logic setup; // APB setup cycle
  logic wr_take; // Write completes this edge
  logic mapped; // Address lands on a register

  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_take = apb_req.psel && apb_req.penable && pready && apb_req.pwrite;
  assign mapped = hit(apb_req.paddr, `PFI_OFF_PE_VER) || hit(apb_req.paddr, `PFI_OFF_PE_IDR)
               || hit(apb_req.paddr, `PFI_OFF_PE_CTRL) || hit(apb_req.paddr, `PFI_OFF_AIDR)
               || hit(apb_req.paddr, `PFI_OFF_IDR_LO) || hit(apb_req.paddr, `PFI_OFF_IDR_HI)
               || hit(apb_req.paddr, `PFI_OFF_IMPL_IDR)
               || hit(apb_req.paddr, `PFI_OFF_BANDWIDTH_USAGE_COUNTER_IDR);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic secure_default_bit_q; // Secure default enable
  logic force_q; // Force non-secure, when writable
  logic secure_default_bit_eff; // Secure default in force
  logic force_eff; // Force non-secure in force

  // Only bits whose feature exists can be set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secure_default_bit_q <= 1'(`PFI_CTRL_RST >> `PFI_CTRL_SDEF);
      force_q <= 1'(`PFI_CTRL_RST >> `PFI_CTRL_FORCE);
    end else if (wr_take && hit(apb_req.paddr, `PFI_OFF_PE_CTRL)) begin
      secure_default_bit_q <= pe_id.secure_default_bit && apb_req.pwdata[`PFI_CTRL_SDEF];
      force_q <= pe_id.force_nonsecure_bit && FORCE_NONSECURE_BIT_RW && apb_req.pwdata[`PFI_CTRL_FORCE];
    end
  end

  // A read-as-one force bit is permanently on
  assign secure_default_bit_eff = pe_id.secure_default_bit && secure_default_bit_q;
  assign force_eff = pe_id.force_nonsecure_bit && (FORCE_NONSECURE_BIT_RW ? force_q : 1'b1);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rd_d; // Word for the addressed register

  // Identification words; writes to them never land anywhere
  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit(apb_req.paddr, `PFI_OFF_PE_VER)) begin
      rd_d[3:0] = pe_id.major;
      rd_d[7:4] = pe_id.frac;
    end else if (hit(apb_req.paddr, `PFI_OFF_PE_IDR)) begin
      rd_d[`PFI_PEIDR_TRAP] = pe_id.trap;
      rd_d[`PFI_PEIDR_SDEF] = pe_id.secure_default_bit;
      rd_d[`PFI_PEIDR_FORCE] = pe_id.force_nonsecure_bit;
    end else if (hit(apb_req.paddr, `PFI_OFF_PE_CTRL)) begin
      rd_d[`PFI_CTRL_SDEF] = secure_default_bit_eff;
      rd_d[`PFI_CTRL_FORCE] = force_eff;
    end else if (hit(apb_req.paddr, `PFI_OFF_AIDR)) begin
      rd_d[7:4] = msc_id.major;
      rd_d[3:0] = msc_id.minor;
    end else if (hit(apb_req.paddr, `PFI_OFF_IDR_LO)) begin
      rd_d[`PFI_IDR_HAS_IMPL] = msc_id.has_impl;
      rd_d[`PFI_IDR_INSTANCE_SELECT_PRESENT_FLAG] = msc_id.instance_select_present_flag;
      rd_d[`PFI_IDR_ERROR_STATUS_PRESENT_FLAG] = msc_id.error_status_present_flag;
      rd_d[`PFI_IDR_HAS_EXTD] = msc_id.has_extd;
      rd_d[`PFI_IDR_EXT] = msc_id.extended_id_flag;
    end else if (hit(apb_req.paddr, `PFI_OFF_IDR_HI)) begin
      // Upper word exists only in the wide form
      if (msc_id.extended_id_flag) begin
        rd_d[`PFI_IDRH_NO_PART] = msc_id.no_part;
        rd_d[`PFI_IDRH_NO_MON] = msc_id.no_mon;
      end
    end else if (hit(apb_req.paddr, `PFI_OFF_IMPL_IDR)) begin
      // Description counts suppressed by their flags
      if (msc_id.has_impl) begin
        rd_d[7:0] = msc_id.no_part ? 8'h00 : IMPL_PART_N;
        rd_d[15:8] = msc_id.no_mon ? 8'h00 : IMPL_MON_N;
      end
    end else if (hit(apb_req.paddr, `PFI_OFF_BANDWIDTH_USAGE_COUNTER_IDR)) begin
      rd_d[`PFI_BANDWIDTH_USAGE_COUNTER_LONG] = msc_id.has_long;
      rd_d[15:8] = msc_id.cnt_w;
    end
  end

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------
  // Answer prepared in setup so every output is a flop; one wait-free access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pready <= 1'b1;
      prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_d;
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Label generation
  // ----------------------------------------------------------------
  // Force wins over secure default: secure labels are unusable then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_ns <= 1'b0;
      out_partition_label <= '0;
      out_pmg <= '0;
    end else begin
      out_valid <= req_valid && (pe_id.major != `PFI_VER_ZERO
                                 || pe_id.frac != `PFI_VER_ZERO);
      if (req_secure && force_eff) begin
        out_ns <= 1'b1;
        out_partition_label <= req_partition_label;
        out_pmg <= req_pmg;
      end else if (req_secure && secure_default_bit_eff) begin
        out_ns <= 1'b0;
        out_partition_label <= '0;
        out_pmg <= '0;
      end else begin
        out_ns <= !req_secure;
        out_partition_label <= req_partition_label;
        out_pmg <= req_pmg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic ris_sel; // Instance selection offered
  assign ris_sel = msc_id.extended_id_flag && msc_id.instance_select_present_flag;

  sequence s_rd_setup(logic [11:0] off);
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit(apb_req.paddr, off);
  endsequence

  sequence s_sec_req;
    req_valid && req_secure;
  endsequence

  AST_PE_NONE: assert property (
    pe_id.major == `PFI_VER_ZERO && pe_id.frac == `PFI_VER_ZERO && req_valid
    |-> ##1 !out_valid && !pe_id.trap && !pe_id.force_nonsecure_bit)
    else $error("no-extension element emitted a label");

  AST_FORCE_NONSECURE_BIT: assert property (
    s_sec_req and (force_eff) |-> ##1 out_ns && out_partition_label == $past(req_partition_label))
    else $error("secure request not forced non-secure");

  AST_V10: assert property (
    pe_id.major == `PFI_VER_ONE && pe_id.frac == `PFI_VER_ZERO
    |-> !pe_id.trap && !pe_id.force_nonsecure_bit)
    else $error("version 1.0 element shows newer feature");

  AST_V11: assert property (
    pe_id.major == `PFI_VER_ONE && pe_id.frac == `PFI_VER_ONE |-> !pe_id.force_nonsecure_bit)
    else $error("version 1.1 element shows force bit");

  AST_AIDR: assert property (
    s_rd_setup(`PFI_OFF_AIDR) |-> ##1 prdata[7:0] != 8'h01)
    else $error("invalid component revision read");

  AST_IDR_NARROW: assert property (
    s_rd_setup(`PFI_OFF_IDR_HI) and (msc_id.minor == `PFI_VER_ZERO)
    |-> ##1 pready && prdata == 32'h0000_0000)
    else $error("upper feature word nonzero on narrow register");

  AST_EXT: assert property (
    s_rd_setup(`PFI_OFF_IDR_LO) |-> ##1 prdata[`PFI_IDR_EXT] == (msc_id.minor == `PFI_VER_ONE))
    else $error("extended flag disagrees with revision");

  AST_TRAP: assert property (
    s_rd_setup(`PFI_OFF_PE_IDR) and (pe_id.frac == `PFI_VER_ONE)
    |-> ##1 prdata[`PFI_PEIDR_TRAP])
    else $error("trap flag missing");

  AST_SECURE_DEFAULT_BIT: assert property (
    s_sec_req and (secure_default_bit_eff && !force_eff) |-> ##1 out_partition_label == '0 && out_pmg == '0 && !out_ns)
    else $error("secure default label not emitted");

  AST_SDEF_V10: assert property (
    pe_id.major == `PFI_VER_ONE && pe_id.frac == `PFI_VER_ZERO |-> !pe_id.secure_default_bit && !secure_default_bit_eff)
    else $error("version 1.0 element reports secure default");

  AST_FORCE_ONLY01: assert property (
    pe_id.force_nonsecure_bit == (pe_id.major == `PFI_VER_ZERO && pe_id.frac == `PFI_VER_ONE))
    else $error("force bit presence wrong for version");

  AST_IMPL: assert property (
    s_rd_setup(`PFI_OFF_IMPL_IDR) and (msc_id.no_part) |-> ##1 prdata[7:0] == 8'h00)
    else $error("partition description present despite flag");

  AST_RIS: assert property (
    ris_sel |-> msc_id.minor == `PFI_VER_ONE)
    else $error("instance selection without extended register");

  AST_LONG: assert property (
    msc_id.has_long |-> msc_id.cnt_w == `PFI_LONG_W_SHORT || msc_id.cnt_w == `PFI_LONG_W_WIDE)
    else $error("illegal long counter width");

  AST_EXTD: assert property (
    msc_id.error_status_present_flag && msc_id.instance_select_present_flag |-> msc_id.has_extd)
    else $error("widened status missing");

  AST_CONST: assert property (
    wr_take |=> $stable(pe_id) && $stable(msc_id))
    else $error("identification changed after write");

  // Revision and presence flags must agree with each other
  AST_IDR_WIDE: assert property (
    msc_id.minor == `PFI_VER_ONE |-> msc_id.extended_id_flag)
    else $error("revision 1.1 component without wide feature register");

  AST_V10_BARE: assert property (
    msc_id.minor == `PFI_VER_ZERO
    |-> !msc_id.extended_id_flag && !msc_id.has_impl && !msc_id.instance_select_present_flag
        && !msc_id.error_status_present_flag && !msc_id.has_long)
    else $error("revision 1.0 component shows a newer feature");

  AST_ESR_FLAG: assert property (
    msc_id.error_status_present_flag |-> msc_id.extended_id_flag && msc_id.minor == `PFI_VER_ONE)
    else $error("error status flag on a revision 1.0 component");

  AST_RIS_NARROW: assert property (
    !msc_id.extended_id_flag |-> !msc_id.instance_select_present_flag)
    else $error("instance selection reported without extended register");

  AST_LONG_RD: assert property (
    s_rd_setup(`PFI_OFF_BANDWIDTH_USAGE_COUNTER_IDR) and (!msc_id.has_long) |-> ##1 prdata == 32'h0000_0000)
    else $error("counter width shown without long counters");

  // A control write cannot switch on a feature that is absent
  sequence s_ctrl_wr;
    wr_take && hit(apb_req.paddr, `PFI_OFF_PE_CTRL);
  endsequence

  AST_SDEF_ABSENT: assert property (
    s_ctrl_wr and (!pe_id.secure_default_bit) |=> !secure_default_bit_eff)
    else $error("secure default enabled without the feature");

  AST_FORCE_OFF: assert property (
    !pe_id.force_nonsecure_bit |-> !force_eff)
    else $error("force bit in effect on a version without it");

  AST_NONE_CTRL: assert property (
    pe_id.major == `PFI_VER_ZERO && pe_id.frac == `PFI_VER_ZERO |-> !secure_default_bit_eff && !force_eff)
    else $error("no-extension element has a control in effect");

endmodule

//--- sim/partition_feature_id_tb.sv
`timescale 1ns/1ps
`include "pfi_regs.svh"

module partition_feature_id_tb;
  import pfi_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0; // 250 MHz clock
  logic presetn = 1'b0; // Active-low reset
  pfi_apb_req_s apb_req = '0; // Shared by all instances
  logic req_valid = 1'b0; // Label request
  logic req_secure = 1'b0;
  logic [15:0] req_partition_label = '0;
  logic [7:0] req_pmg = '0;
  logic pready_w [4]; // One slot per version flavour
  logic [31:0] prdata_w [4];
  logic pslverr_w [4];
  logic ov [4];
  logic ons [4];
  logic [15:0] opart [4];
  logic [7:0] opmg [4];
  int err_count = 0;
  int num_checks = 0;

  // Free-running clock
  always #2 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Four flavours: 1.1 element, 0.1 element, 1.0 element, no extension
  // ----------------------------------------------------------------
  pfi_top #(.PE_VER(PFI_PE_V11)) pfi_top_inst (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready_w[0]),
    .prdata(prdata_w[0]), .pslverr(pslverr_w[0]), .req_valid(req_valid),
    .req_secure(req_secure), .req_partition_label(req_partition_label), .req_pmg(req_pmg),
    .out_valid(ov[0]), .out_ns(ons[0]), .out_partition_label(opart[0]), .out_pmg(opmg[0]));
  // Component left without newer features, so it must read as 1.0
  pfi_top #(.PE_VER(PFI_PE_V01), .HAS_IMPL(1'b0), .INSTANCE_SELECT_PRESENT_FLAG(1'b0),
    .ERROR_STATUS_PRESENT_FLAG(1'b0), .HAS_LONG(1'b0)) pfi_top_v01_inst (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready_w[1]),
    .prdata(prdata_w[1]), .pslverr(pslverr_w[1]), .req_valid(req_valid),
    .req_secure(req_secure), .req_partition_label(req_partition_label), .req_pmg(req_pmg),
    .out_valid(ov[1]), .out_ns(ons[1]), .out_partition_label(opart[1]), .out_pmg(opmg[1]));
  // Secure default asked for, but a 1.0 element must hide it
  pfi_top #(.PE_VER(PFI_PE_V10)) pfi_top_v10_inst (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready_w[2]),
    .prdata(prdata_w[2]), .pslverr(pslverr_w[2]), .req_valid(req_valid),
    .req_secure(req_secure), .req_partition_label(req_partition_label), .req_pmg(req_pmg),
    .out_valid(ov[2]), .out_ns(ons[2]), .out_partition_label(opart[2]), .out_pmg(opmg[2]));
  pfi_top #(.PE_VER(PFI_PE_NONE), .MSC_EN(1'b0)) pfi_top_none_inst (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready_w[3]),
    .prdata(prdata_w[3]), .pslverr(pslverr_w[3]), .req_valid(req_valid),
    .req_secure(req_secure), .req_partition_label(req_partition_label), .req_pmg(req_pmg),
    .out_valid(ov[3]), .out_ns(ons[3]), .out_partition_label(opart[3]), .out_pmg(opmg[3]));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Verdict and end of run
  task automatic stop_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Case equality, so an unknown never matches
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high
  task automatic apb(input int idx, input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_w[idx] !== 1'b1);
    // No wait states: answer at the first access edge
    chk("pready_wait", 32'(n), 32'h1);
    rd = prdata_w[idx];
    er = pslverr_w[idx];
    apb_req <= '0;
  endtask

  // Read and compare data and error response
  task automatic rdchk(input int idx, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic er;
    apb(idx, 1'b0, a, 32'h0, rd, er);
    chk("prdata", rd, exp);
    chk("pslverr", 32'(er), 32'h0);
  endtask

  // Write that must be accepted without error
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(0, 1'b1, a, d, rd, er);
    chk("pslverr", 32'(er), 32'h0);
  endtask

  // One label request; bit i of the masks is the expectation for flavour i
  task automatic lbl(input logic sec, input logic [2:0] ns_e, input logic [2:0] dflt_e);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_secure <= sec;
    req_partition_label <= 16'h1234;
    req_pmg <= 8'h5A;
    @(posedge pclk);
    req_valid <= 1'b0;
    @(negedge pclk);
    for (int i = 0; i < 3; i++) begin
      chk("out_valid", 32'(ov[i]), 32'h1);
      chk("out_ns", 32'(ons[i]), 32'(ns_e[i]));
      chk("out_partition_label", 32'(opart[i]), dflt_e[i] ? 32'h0 : 32'h1234);
      chk("out_pmg", 32'(opmg[i]), dflt_e[i] ? 32'h0 : 32'h5A);
    end
    chk("out_valid_none", 32'(ov[3]), 32'h0);
    @(negedge pclk);
    chk("out_valid_drop", 32'(ov[0]), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Element version and presence flags of every flavour
  task automatic t_pe_ids();
    logic [31:0] ver_e [4] = '{32'h11, 32'h10, 32'h01, 32'h00};
    logic [31:0] idr_e [4] = '{32'h3, 32'h7, 32'h0, 32'h0};
    for (int i = 0; i < 4; i++) begin
      rdchk(i, `PFI_OFF_PE_VER, ver_e[i]);
      rdchk(i, `PFI_OFF_PE_IDR, idr_e[i]);
    end
  endtask

  // Component identification: full 1.1, bare 1.0, none
  task automatic t_msc_ids();
    logic [11:0] off [5] = '{`PFI_OFF_AIDR, `PFI_OFF_IDR_LO, `PFI_OFF_IDR_HI,
                            `PFI_OFF_IMPL_IDR, `PFI_OFF_BANDWIDTH_USAGE_COUNTER_IDR};
    logic [31:0] exp [5] = '{32'h11, 32'h8000000F, 32'h1, 32'h200, 32'h2C01};
    for (int i = 0; i < 5; i++) begin
      rdchk(0, off[i], exp[i]);
    end
    rdchk(1, `PFI_OFF_AIDR, 32'h10);
    rdchk(1, `PFI_OFF_IDR_LO, 32'h0);
    rdchk(1, `PFI_OFF_IDR_HI, 32'h0);
    rdchk(3, `PFI_OFF_AIDR, 32'h0);
  endtask

  // Labels at reset, then control bits and labels after setting them
  task automatic t_ctrl_labels();
    logic [31:0] ctl_e [4] = '{32'h1, 32'h3, 32'h0, 32'h0};
    lbl(1'b1, 3'b000, 3'b000);
    wr(`PFI_OFF_PE_CTRL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      rdchk(i, `PFI_OFF_PE_CTRL, ctl_e[i]);
    end
    lbl(1'b1, 3'b010, 3'b001);
    lbl(1'b0, 3'b111, 3'b000);
    wr(`PFI_OFF_PE_CTRL, 32'h0);
    rdchk(1, `PFI_OFF_PE_CTRL, 32'h0);
  endtask

  // Identification words ignore writes
  task automatic t_read_only();
    logic [11:0] off [4] = '{`PFI_OFF_PE_VER, `PFI_OFF_PE_IDR, `PFI_OFF_AIDR, `PFI_OFF_IDR_LO};
    logic [31:0] exp [4] = '{32'h11, 32'h3, 32'h11, 32'h8000000F};
    for (int i = 0; i < 4; i++) begin
      wr(off[i], 32'hFFFFFFFF);
      rdchk(0, off[i], exp[i]);
    end
  endtask

  // Unmapped place: error response, zero data
  task automatic t_unmapped();
    logic [31:0] rd;
    logic er;
    apb(0, 1'b0, 12'h024, 32'h0, rd, er);
    chk("bad_rd_err", 32'(er), 32'h1);
    chk("bad_rd_data", rd, 32'h0);
    apb(0, 1'b1, 12'h100, 32'hFFFFFFFF, rd, er);
    chk("bad_wr_err", 32'(er), 32'h1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  // Reset for two cycles, then every scenario in turn
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_pe_ids();
    t_msc_ids();
    t_ctrl_labels();
    t_read_only();
    t_unmapped();
    stop_test();
  end

  // The whole run needs well under a thousand cycles
  initial begin
    #40000;
    err_count++;
    stop_test();
  end

endmodule
